// ### core/periph_irq_pkg.sv
// Package with register selects, field positions and masks of the peripheral interrupt registers.
package periph_irq_pkg;

   // Register selects on the core register port (no offsets are printed, so these are local codes).
   localparam logic [1:0] SEL_ENABLE_A = 2'h0;
   localparam logic [1:0] SEL_ENABLE_B = 2'h1;
   localparam logic [1:0] SEL_FLAGS_A  = 2'h2;
   localparam logic [1:0] SEL_FLAGS_B  = 2'h3;

   // Field positions in the first pair of registers.
   localparam int BIT_T1_GATE     = 7;
   localparam int BIT_ADC_DONE    = 6;
   localparam int BIT_LIMIT_TIMER = 2;
   localparam int BIT_T2_MATCH    = 1;
   localparam int BIT_T1_ROLLOVER = 0;

   // Field positions in the second pair of registers.
   localparam int BIT_CMP_B        = 5;
   localparam int BIT_CMP_A        = 4;
   localparam int BIT_COMP_OUT_GEN = 2;
   localparam int BIT_CAPCMP       = 0;

   // Implemented-bit masks; every other bit reads as zero.
   localparam logic [7:0] MASK_A = 8'hC7;
   localparam logic [7:0] MASK_B = 8'h35;

   // Reset value of all four registers.
   localparam logic [7:0] RESET_VALUE = 8'h00;

   // Operating modes of the capture/compare unit.
   typedef enum logic [1:0] {
      CCP_CAPTURE,
      CCP_COMPARE,
      CCP_PWM,
      CCP_OFF
   } ccp_mode_t;

endpackage

// ### core/periph_irq_if.sv
// Interface joining the peripheral event side to the interrupt flag and enable block.
`timescale 1ns/1ps
`default_nettype none
interface periph_irq_if;
   import periph_irq_pkg::*;

   logic       t1_gate_evt;     // Timer1 gate event pulse.
   logic       adc_done_evt;    // Conversion complete pulse.
   logic       limit_timer_evt; // Limit timer count equals its period.
   logic       t2_match_evt;    // Timer2 count equals its period.
   logic       t1_rollover_evt; // Timer1 16-bit rollover pulse.
   logic       cmp_a_output;    // Comparator A output level.
   logic       cmp_b_output;    // Comparator B output level.
   logic       cog_shutdown_evt;// Output generator auto-shutdown request.
   logic       capcmp_evt;      // Capture or compare match pulse.
   ccp_mode_t  ccp_mode;        // Current capture/compare mode.

   modport source (
      output t1_gate_evt, adc_done_evt, limit_timer_evt, t2_match_evt, t1_rollover_evt,
      output cmp_a_output, cmp_b_output, cog_shutdown_evt, capcmp_evt, ccp_mode
   );
   modport flags (
      input t1_gate_evt, adc_done_evt, limit_timer_evt, t2_match_evt, t1_rollover_evt,
      input cmp_a_output, cmp_b_output, cog_shutdown_evt, capcmp_evt, ccp_mode
   );
endinterface
`default_nettype wire

// ### core/periph_event_source.sv
// Peripheral end: registers the raw peripheral event strobes onto the interface.
`timescale 1ns/1ps
`default_nettype none
module periph_event_source
   import periph_irq_pkg::*;
(
   // Clock and reset.
   input  wire logic  clk_sys_i,
   input  wire logic  rst_b_i,
   // Raw events from the peripherals, all on the core clock.
   input  wire logic  t1_gate_i,
   input  wire logic  adc_done_i,
   input  wire logic  limit_timer_match_i,
   input  wire logic  t2_match_i,
   input  wire logic  t1_rollover_i,
   input  wire logic  cmp_a_output_i,
   input  wire logic  cmp_b_output_i,
   input  wire logic  cog_shutdown_i,
   input  wire logic  capcmp_i,
   input  wire ccp_mode_t ccp_mode_i,
   // Link to the flag block.
   periph_irq_if.source link
);

   // Event pulses are registered so the far end sees clean one-cycle strobes.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         link.t1_gate_evt      <= 1'b0;
         link.adc_done_evt     <= 1'b0;
         link.limit_timer_evt  <= 1'b0;
         link.t2_match_evt     <= 1'b0;
         link.t1_rollover_evt  <= 1'b0;
         link.cog_shutdown_evt <= 1'b0;
         link.capcmp_evt       <= 1'b0;
      end
      else
      begin
         link.t1_gate_evt      <= t1_gate_i;
         link.adc_done_evt     <= adc_done_i;
         link.limit_timer_evt  <= limit_timer_match_i;
         link.t2_match_evt     <= t2_match_i;
         link.t1_rollover_evt  <= t1_rollover_i;
         link.cog_shutdown_evt <= cog_shutdown_i;
         link.capcmp_evt       <= capcmp_i;
      end
   end

   // Comparator levels and the mode are passed as registered levels.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         link.cmp_a_output <= 1'b0;
         link.cmp_b_output <= 1'b0;
         link.ccp_mode     <= CCP_OFF;
      end
      else
      begin
         link.cmp_a_output <= cmp_a_output_i;
         link.cmp_b_output <= cmp_b_output_i;
         link.ccp_mode     <= ccp_mode_i;
      end
   end

endmodule
`default_nettype wire

// ### core/periph_irq_flags.sv
// Core end: peripheral interrupt enable and flag registers with the request to the core.
`timescale 1ns/1ps
`default_nettype none
module periph_irq_flags
   import periph_irq_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk_sys_i,
   input  wire logic       rst_b_i,
   // Core register port.
   input  wire logic [1:0] reg_sel_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // Enables held in the core interrupt control register.
   input  wire logic       periph_master_irq_en_i,
   input  wire logic       global_irq_en_i,
   // Interrupt request toward the core.
   output logic            periph_irq_o,
   // Link from the peripherals.
   periph_irq_if.flags     link
);

   // Register state.
   logic [7:0] enable_a_q; // First enable register.
   logic [7:0] enable_b_q; // Second enable register.
   logic [7:0] flags_a_q;  // First flag register.
   logic [7:0] flags_b_q;  // Second flag register.
   logic [7:0] set_a;      // Hardware set vector for the first flags.
   logic [7:0] set_b;      // Hardware set vector for the second flags.
   logic       cmp_a_prev_q; // Last comparator A level, for change detection.
   logic       cmp_b_prev_q; // Last comparator B level.
   logic       cmp_settle_q; // High once the link carries a sampled level rather than its reset value.
   logic       cmp_primed_q; // High once the history holds a sampled level as well.

   // Comparator history. The source end registers the levels once more, so on the first edge
   // after release the link still shows its reset level, and the history holds a real level
   // only one edge later. Change detection waits for both, so a comparator that idles high
   // does not fake a change when reset is released; the cost is that the level present at
   // release is taken as the starting point and is never flagged by itself.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         // History and priming restart together.
         cmp_a_prev_q <= 1'b0;
         cmp_b_prev_q <= 1'b0;
         cmp_settle_q <= 1'b0;
         cmp_primed_q <= 1'b0;
      end
      else
      begin
         // Levels are tracked every cycle; priming ripples through two stages.
         cmp_a_prev_q <= link.cmp_a_output;
         cmp_b_prev_q <= link.cmp_b_output;
         cmp_settle_q <= 1'b1;
         cmp_primed_q <= cmp_settle_q;
      end
   end

   // Set vectors are built with no regard to any enable bit, so a flag records an event
   // even while the core has it masked. Each bit is a one-cycle strobe here; a level held
   // for several cycles just sets the same flag again, which is harmless because the flags
   // are sticky.
   always_comb
   begin
      set_a = 8'h00;
      set_b = 8'h00;
      // First flags: timer, gate and conversion strobes.
      set_a[BIT_T1_GATE]     = link.t1_gate_evt;
      set_a[BIT_ADC_DONE]    = link.adc_done_evt;
      set_a[BIT_LIMIT_TIMER] = link.limit_timer_evt;
      set_a[BIT_T2_MATCH]    = link.t2_match_evt;
      set_a[BIT_T1_ROLLOVER] = link.t1_rollover_evt;
      // Second flags: a comparator flags any change of its level once primed.
      set_b[BIT_CMP_B] = cmp_primed_q && (link.cmp_b_output != cmp_b_prev_q);
      set_b[BIT_CMP_A] = cmp_primed_q && (link.cmp_a_output != cmp_a_prev_q);
      // Shutdown requests are plain strobes; capture/compare depends on the mode.
      set_b[BIT_COMP_OUT_GEN] = link.cog_shutdown_evt;
      // PWM and idle modes leave the flag unused.
      set_b[BIT_CAPCMP] = link.capcmp_evt &&
                          (link.ccp_mode == CCP_CAPTURE || link.ccp_mode == CCP_COMPARE);
   end

   // Enable registers: plain read/write of the implemented bits only. The unused bits are
   // dropped on the way in and masked again on the way out, so the stored state itself
   // never holds a bit that could be mistaken for an enable. Software should clear a flag
   // before it sets the matching enable, or a stale event asks at once.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         // Every interrupt source starts masked.
         enable_a_q <= RESET_VALUE;
         enable_b_q <= RESET_VALUE;
      end
      else if (reg_wr_i)
      begin
         // A write touches only the register that the select names.
         if (reg_sel_i == SEL_ENABLE_A)
         begin
            // First enable register.
            enable_a_q <= reg_wdata_i & MASK_A;
         end
         if (reg_sel_i == SEL_ENABLE_B)
         begin
            // Second enable register.
            enable_b_q <= reg_wdata_i & MASK_B;
         end
      end
   end

   // Flag registers: software may write either value, but a hardware set in the
   // same cycle wins so an event coinciding with a clear is never lost. Writing a
   // one sets a flag as well, which lets software raise a request for test; the
   // flags latch with no regard to any enable, so a stale event waits here.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         // No event is pending after reset.
         flags_a_q <= RESET_VALUE;
         flags_b_q <= RESET_VALUE;
      end
      else
      begin
         if (reg_wr_i && reg_sel_i == SEL_FLAGS_A)
         begin
            // Software write to the first flags, merged with this cycle's events.
            flags_a_q <= (reg_wdata_i | set_a) & MASK_A;
         end
         else
         begin
            // Flags are sticky: they only gather new events.
            flags_a_q <= (flags_a_q | set_a) & MASK_A;
         end
         if (reg_wr_i && reg_sel_i == SEL_FLAGS_B)
         begin
            // Software write to the second flags, merged with this cycle's events.
            flags_b_q <= (reg_wdata_i | set_b) & MASK_B;
         end
         else
         begin
            // Sticky as above.
            flags_b_q <= (flags_b_q | set_b) & MASK_B;
         end
      end
   end

   // Read data is registered; it shows the selected register one cycle after selection.
   // Reads have no side effects, so a flag is never lost to a read that races an event,
   // and the unused bits are forced low once more on the way out.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         // The bus reads zero while in reset.
         reg_rdata_o <= RESET_VALUE;
      end
      else
      begin
         // All four select codes are in use, so no default is needed.
         unique case (reg_sel_i)
            SEL_ENABLE_A: reg_rdata_o <= enable_a_q & MASK_A;
            SEL_ENABLE_B: reg_rdata_o <= enable_b_q & MASK_B;
            SEL_FLAGS_A:  reg_rdata_o <= flags_a_q & MASK_A;
            SEL_FLAGS_B:  reg_rdata_o <= flags_b_q & MASK_B;
         endcase
      end
   end

   // Request to the core. It is registered so the output comes from a flip-flop;
   // the cost is one cycle of latency from flag or enable to request. Both core
   // enables gate the request here, never the flags, so clearing either enable
   // hides a pending event without losing it.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_b_i)
      begin
         // No request while in reset.
         periph_irq_o <= 1'b0;
      end
      else
      begin
         // Any enabled pending flag asks, if the core lets peripherals through.
         periph_irq_o <= (|(flags_a_q & enable_a_q) || |(flags_b_q & enable_b_q))
                         && periph_master_irq_en_i && global_irq_en_i;
      end
   end

endmodule
`default_nettype wire

// ### verification/periph_irq_assertions.sv
// Concurrent checks on the flag block register port and on the event link.
`timescale 1ns/1ps
`default_nettype none
module periph_irq_assertions
   import periph_irq_pkg::*;
(
   // Clock, reset and core side.
   input wire logic       clk_sys_i,
   input wire logic       rst_b_i,
   input wire logic [1:0] reg_sel_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       periph_master_irq_en_i,
   input wire logic       global_irq_en_i,
   input wire logic       periph_irq_o,
   // Event link.
   input wire logic       t2_match_evt,
   input wire logic       t1_rollover_evt,
   input wire logic       limit_timer_evt,
   input wire logic       adc_done_evt,
   input wire logic       cmp_a_output,
   input wire logic       cmp_b_output,
   input wire logic       capcmp_evt,
   input wire ccp_mode_t  ccp_mode
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   // A link event, then the matching flag register selected on the next edge.
   sequence ev_read(ev, s);
      ev ##1 reg_sel_i == s;
   endsequence

   unused_a_bits_a: assert property (!$past(reg_sel_i[0]) |-> (reg_rdata_o & ~MASK_A) == 8'h00)
      else $error("unused bit set in register pair a");
   unused_b_bits_a: assert property ($past(reg_sel_i[0]) |-> (reg_rdata_o & ~MASK_B) == 8'h00)
      else $error("unused bit set in register pair b");
   master_gate_a: assert property (!$past(periph_master_irq_en_i) |-> !periph_irq_o)
      else $error("request passed with master enable clear");
   global_gate_a: assert property (!$past(global_irq_en_i) |-> !periph_irq_o)
      else $error("request passed with global enable clear");
   rollover_flag_a: assert property (ev_read(t1_rollover_evt, SEL_FLAGS_A) |=> reg_rdata_o[BIT_T1_ROLLOVER])
      else $error("rollover flag not set");
   t2_flag_a: assert property (ev_read(t2_match_evt, SEL_FLAGS_A) |=> reg_rdata_o[BIT_T2_MATCH])
      else $error("timer2 flag not set");
   limit_flag_a: assert property (ev_read(limit_timer_evt, SEL_FLAGS_A) |=> reg_rdata_o[BIT_LIMIT_TIMER])
      else $error("limit timer flag not set");
   adc_flag_a: assert property (ev_read(adc_done_evt, SEL_FLAGS_A) |=> reg_rdata_o[BIT_ADC_DONE])
      else $error("conversion flag not set");
   // A level change against the reset value in the first two edges after release is not a real change.
   cmp_a_flag_a: assert property (ev_read($past(rst_b_i, 2) && cmp_a_output != $past(cmp_a_output),
      SEL_FLAGS_B) |=> reg_rdata_o[BIT_CMP_A]) else $error("comparator a change flag not set");
   cmp_b_flag_a: assert property (ev_read($past(rst_b_i, 2) && cmp_b_output != $past(cmp_b_output),
      SEL_FLAGS_B) |=> reg_rdata_o[BIT_CMP_B]) else $error("comparator b change flag not set");
   capcmp_flag_a: assert property (ev_read(capcmp_evt && ccp_mode inside {CCP_CAPTURE, CCP_COMPARE},
      SEL_FLAGS_B) |=> reg_rdata_o[BIT_CAPCMP]) else $error("capture or compare flag not set");
endmodule
`default_nettype wire

// ### verification/peripheral_irq_enable_flags_tb.sv
// Self-checking bench joining the event source to the flag block.
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_enable_flags_tb;
   import periph_irq_pkg::*;
   logic        clk_sys_i, rst_b_i, reg_wr_i, periph_master_irq_en_i, global_irq_en_i, periph_irq_o;
   logic        rd_vld, vld_d, irq_x, b;  // Read marker, its delayed copy, expected request, register choice.
   logic [1:0]  reg_sel_i, cmp_lvl, md;
   logic [7:0]  reg_wdata_i, reg_rdata_o;
   logic [15:0] ev_q, en, fl;            // Pulses and flags share one layout: pair b above pair a.
   logic [8:0]  expq[$];                 // Expected request and read data, oldest first.
   integer      seed = 32'ha3ce;
   int          bad_count = 0;
   int          num_checks = 0;
   periph_irq_if link ();
   periph_event_source periph_event_source_inst (.clk_sys_i, .rst_b_i, .t1_gate_i(ev_q[7]), .adc_done_i(ev_q[6]),
      .limit_timer_match_i(ev_q[2]), .t2_match_i(ev_q[1]), .t1_rollover_i(ev_q[0]), .cmp_a_output_i(cmp_lvl[0]),
      .cmp_b_output_i(cmp_lvl[1]), .cog_shutdown_i(ev_q[10]), .capcmp_i(ev_q[8]), .ccp_mode_i(ccp_mode_t'(md)), .link);
   periph_irq_flags periph_irq_flags_inst (.clk_sys_i, .rst_b_i, .reg_sel_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
      .periph_master_irq_en_i, .global_irq_en_i, .periph_irq_o, .link);
   periph_irq_assertions periph_irq_assertions_inst (.clk_sys_i, .rst_b_i, .reg_sel_i, .reg_rdata_o,
      .periph_master_irq_en_i, .global_irq_en_i, .periph_irq_o, .t2_match_evt(link.t2_match_evt),
      .t1_rollover_evt(link.t1_rollover_evt), .limit_timer_evt(link.limit_timer_evt), .adc_done_evt(link.adc_done_evt),
      .cmp_a_output(link.cmp_a_output), .cmp_b_output(link.cmp_b_output), .capcmp_evt(link.capcmp_evt),
      .ccp_mode(link.ccp_mode));

   // Free-running system clock.
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         $display("ERROR irq_and_rdata expected %h seen %h", exp, seen);
         bad_count++;
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task print_verdict;
      $display("Comparisons %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // One register write; the strobe drops on the edge that takes it.
   task wr(input logic [1:0] s, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_sel_i <= s;
      reg_wr_i <= 1'b1;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask

   // One register read; the expectation is queued for the monitor.
   task rd(input logic [1:0] s, input logic [7:0] e);
      @(posedge clk_sys_i);
      reg_sel_i <= s;
      rd_vld <= 1'b1;
      expq.push_back({irq_x, e});
      @(posedge clk_sys_i);
      rd_vld <= 1'b0;
   endtask

   // Read data lands one edge after the select, so the marker is delayed to match.
   always @(posedge clk_sys_i) vld_d <= rd_vld;
   always @(negedge clk_sys_i) if (vld_d === 1'b1) chk({periph_irq_o, reg_rdata_o}, expq.pop_front());

   // Main sequence: reset values, then random enables, events and gates.
   initial
   begin
      {rst_b_i, reg_wr_i, rd_vld, periph_master_irq_en_i, global_irq_en_i, irq_x} <= 6'h00;
      {reg_sel_i, md, reg_wdata_i, ev_q} <= 28'h000_0000;
      cmp_lvl <= 2'h3; // Comparators idle high, so the reset reads also show no false change.
      repeat (12) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      for (int s = 0; s < 4; s++) rd(s[1:0], RESET_VALUE);
      for (int i = 0; i < 24; i++)
      begin
         en = 16'($random(seed));
         fl = 16'($random(seed)) & {MASK_B, MASK_A};
         md <= 2'($random(seed));
         {periph_master_irq_en_i, global_irq_en_i} <= 2'($random(seed));
         wr(SEL_FLAGS_A, 8'h00);
         wr(SEL_FLAGS_B, 8'h00);
         wr(SEL_ENABLE_A, en[7:0]);
         wr(SEL_ENABLE_B, en[15:8]);
         irq_x = 1'b0;
         rd(SEL_ENABLE_A, en[7:0] & MASK_A);
         rd(SEL_ENABLE_B, en[15:8] & MASK_B);
         // Pulses land with the enables already set, so the flags must rise regardless.
         @(posedge clk_sys_i);
         ev_q <= fl;
         cmp_lvl <= cmp_lvl ^ fl[13:12];
         @(posedge clk_sys_i);
         ev_q <= 16'h0000;
         if (md > 2'h1) fl[BIT_CAPCMP + 8] = 1'b0;
         irq_x = |(fl & en) & periph_master_irq_en_i & global_irq_en_i;
         for (int j = 0; j < 2; j++)
         begin
            b = i[0] ^ j[0];
            rd({1'b1, b}, b ? fl[15:8] : fl[7:0]);
         end
         rd(SEL_FLAGS_A, fl[7:0]);
      end
      repeat (3) @(posedge clk_sys_i);
      print_verdict();
   end

   // Watchdog: the sequence needs under 1000 cycles, so 5000 means a hang.
   initial
   begin
      #50000;
      bad_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
